// ---- rtl/cfa_card_file_access.v ----
`timescale 1ns/1ns
`include "cfa_defines.vh"
module cfa_card_file_access (
    // clock, enable and reset
    input wire REF_CLK_I,
    input wire RESET_N_I,
    input wire CE_I,
    // axi4-lite write address
    input wire AWVALID_I,
    output wire AWREADY_O,
    input wire [7:0] AWADDR_I,
    // axi4-lite write data
    input wire WVALID_I,
    output wire WREADY_O,
    input wire [31:0] WDATA_I,
    input wire [3:0] WSTRB_I,
    // axi4-lite write response
    output reg BVALID_O,
    input wire BREADY_I,
    output reg [1:0] BRESP_O,
    // axi4-lite read address
    input wire ARVALID_I,
    output wire ARREADY_O,
    input wire [7:0] ARADDR_I,
    // axi4-lite read data
    output reg RVALID_O,
    input wire RREADY_I,
    output reg [31:0] RDATA_O,
    output reg [1:0] RRESP_O
);

// ====================================================
// states and sources
localparam S_IDLE = 3'b001;
localparam S_DEC = 3'b010;
localparam S_RUN = 3'b100;
localparam SRC_MEM = 2'h0;
localparam SRC_SEL = 2'h1;
localparam SRC_NAME = 2'h2;

// mapped register check
function addr_ok;
    input [7:0] a;
    begin
        addr_ok = (a == `CFA_OFF_CMD) || (a == `CFA_OFF_STAT) ||
            (a == `CFA_OFF_FILE) || (a == `CFA_OFF_APP) ||
            (a == `CFA_OFF_WDATA) || (a == `CFA_OFF_RDATA);
    end
endfunction

// byte-strobe merge
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
        merge = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
                merge[k*8 +: 8] = nw[k*8 +: 8];
            end
        end
    end
endfunction

// ====================================================
// storage and control state
reg [2:0] state;
reg [7:0] mem [0:63];
reg [7:0] wbuf [0:63];
reg [7:0] resp [0:63];
reg [31:0] cmd;
reg [31:0] file_cfg;
reg [31:0] app_name;
reg [3:0] ptr;
reg [1:0] app_ind;
reg done;
reg err;
reg [6:0] resp_len;
reg [6:0] wr_idx;
reg [6:0] rd_idx;
reg [6:0] idx;
reg [5:0] r_base;
reg [6:0] r_cnt;
reg [1:0] r_src;
reg r_wr;
reg [3:0] r_ptr;
reg [1:0] r_app;
reg aw_hold;
reg w_hold;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
integer i;

// command and file fields
wire [1:0] cmd_op = cmd[1:0];
wire cmd_le_empty = cmd[2];
wire [7:0] cmd_p1 = cmd[15:8];
wire [7:0] cmd_p2 = cmd[23:16];
wire [7:0] cmd_len = cmd[31:24];
wire [1:0] file_type = file_cfg[1:0];
wire rd_ok = file_cfg[2];
wire up_ok = file_cfg[3];
wire [3:0] nrec = file_cfg[7:4];
wire [4:0] sfi_val = file_cfg[12:8];
wire sfi_present = file_cfg[13];
wire [15:0] file_id = file_cfg[31:16];
wire [4:0] eff_sfi = sfi_present ? sfi_val : file_id[4:0];
wire [4:0] rec_sfi = cmd_p2[7:3];
wire [2:0] rec_mode = cmd_p2[2:0];

// ====================================================
// axi handshakes
assign AWREADY_O = CE_I & ~aw_hold & ~BVALID_O;
assign WREADY_O = CE_I & ~w_hold & ~BVALID_O;
assign ARREADY_O = CE_I & ~RVALID_O;
wire do_write = aw_hold & w_hold & ~BVALID_O;
wire do_read = ARVALID_I & ARREADY_O;
wire wr_cmd = do_write && (aw_addr == `CFA_OFF_CMD);
wire start = wr_cmd && (state == S_IDLE) && w_strb[0];

// ====================================================
// command decode
reg d_err;
reg [15:0] d_off;
reg [8:0] d_cnt;
reg [8:0] d_nat;
reg [1:0] d_src;
reg d_wr;
reg [3:0] d_rec;
reg [3:0] d_ptr;
reg [1:0] d_app;
always @* begin
    d_err = 1'b0;
    d_off = 16'h0000;
    d_cnt = 9'h000;
    d_nat = 9'h000;
    d_src = SRC_MEM;
    d_wr = 1'b0;
    d_rec = 4'h0;
    d_ptr = ptr;
    d_app = app_ind;
    case (cmd_op)
        `CFA_OP_STATUS: begin
            case (cmd_p1)
                `CFA_P1_NONE: d_app = 2'b00;
                `CFA_P1_INIT: d_app = 2'b01;
                `CFA_P1_TERM: d_app = 2'b10;
                default: d_err = 1'b1;
            endcase
            case (cmd_p2)
                `CFA_P2_SELECT: begin
                    d_nat = `CFA_SEL_LEN;
                    d_src = SRC_SEL;
                end
                `CFA_P2_NAME: begin
                    d_nat = `CFA_NAME_LEN;
                    d_src = SRC_NAME;
                end
                `CFA_P2_NODATA: d_nat = 9'h000;
                default: d_err = 1'b1;
            endcase
            // empty or zero length takes the full response
            if (cmd_le_empty || cmd_len == 8'h00 ||
                {1'b0, cmd_len} > d_nat) begin
                d_cnt = d_nat;
            end else begin
                d_cnt = {1'b0, cmd_len};
            end
        end
        `CFA_OP_RD_BIN, `CFA_OP_UP_BIN: begin
            if (!cmd_p1[7]) begin
                d_off = {1'b0, cmd_p1[6:0], cmd_p2};
            end else if (cmd_p1[6:5] == 2'b00) begin
                d_off = {8'h00, cmd_p2};
                if (cmd_p1[4:0] != eff_sfi) begin
                    d_err = 1'b1;
                end
            end else begin
                d_err = 1'b1;
            end
            if (file_type != `CFA_FT_TRANSP) begin
                d_err = 1'b1;
            end
            if (cmd_op == `CFA_OP_RD_BIN) begin
                if (!rd_ok || cmd_le_empty) begin
                    d_err = 1'b1;
                end
                d_cnt = (cmd_len == 8'h00) ? `CFA_BIN_LE0 :
                    {1'b0, cmd_len};
            end else begin
                // data staged must match the command length
                if (!up_ok || {1'b0, wr_idx} != cmd_len) begin
                    d_err = 1'b1;
                end
                d_cnt = {1'b0, cmd_len};
                d_wr = 1'b1;
            end
            if (d_off + {7'h00, d_cnt} > `CFA_MEM_BYTES) begin
                d_err = 1'b1;
            end
        end
        default: begin
            if (file_type == `CFA_FT_TRANSP || !rd_ok ||
                nrec == 4'h0 || nrec > `CFA_MAX_REC) begin
                d_err = 1'b1;
            end
            if (rec_sfi == `CFA_SFI_RFU) begin
                d_err = 1'b1;
            end else if (rec_sfi != 5'h00 && rec_sfi != eff_sfi) begin
                d_err = 1'b1;
            end
            case (rec_mode)
                `CFA_RM_NEXT: begin
                    if (ptr == 4'h0) begin
                        d_rec = 4'h1;
                    end else if (ptr >= nrec) begin
                        if (file_type == `CFA_FT_CYCLIC) begin
                            d_rec = 4'h1;
                        end else begin
                            d_err = 1'b1;
                        end
                    end else begin
                        d_rec = ptr + 4'h1;
                    end
                    d_ptr = d_rec;
                end
                `CFA_RM_PREV: begin
                    if (ptr == 4'h0) begin
                        d_rec = nrec;
                    end else if (ptr == 4'h1) begin
                        if (file_type == `CFA_FT_CYCLIC) begin
                            d_rec = nrec;
                        end else begin
                            d_err = 1'b1;
                        end
                    end else begin
                        d_rec = ptr - 4'h1;
                    end
                    d_ptr = d_rec;
                end
                `CFA_RM_ABS: begin
                    if (cmd_p1 == 8'h00) begin
                        d_rec = ptr;
                        if (ptr == 4'h0) begin
                            d_err = 1'b1;
                        end
                    end else if (cmd_p1 > {4'h0, nrec}) begin
                        d_err = 1'b1;
                    end else begin
                        d_rec = cmd_p1[3:0];
                    end
                end
                default: d_err = 1'b1;
            endcase
            d_off = {9'h000, d_rec - 4'h1, 3'b000};
            if (cmd_le_empty || cmd_len == 8'h00) begin
                d_cnt = `CFA_REC_LEN;
            end else begin
                d_cnt = {1'b0, cmd_len};
            end
            if (d_cnt > `CFA_REC_LEN) begin
                d_err = 1'b1;
            end
        end
    endcase
end

// ====================================================
// source byte for the copy loop
reg [7:0] sbyte;
always @* begin
    case (r_src)
        SRC_SEL: begin
            case (idx[1:0])
                2'h0: sbyte = file_id[15:8];
                2'h1: sbyte = file_id[7:0];
                default: sbyte = {3'b000, eff_sfi};
            endcase
        end
        SRC_NAME: sbyte = app_name[31 - idx[1:0]*8 -: 8];
        default: sbyte = mem[r_base + idx[5:0]];
    endcase
end

// ====================================================
// read data mux
reg [31:0] rmux;
always @* begin
    case (ARADDR_I)
        `CFA_OFF_CMD: rmux = cmd;
        `CFA_OFF_STAT: rmux = {1'b0, wr_idx, 6'h00, app_ind,
            1'b0, resp_len, ptr, 1'b0, err, done, state != S_IDLE};
        `CFA_OFF_FILE: rmux = file_cfg;
        `CFA_OFF_APP: rmux = app_name;
        `CFA_OFF_WDATA: rmux = {25'h000_0000, wr_idx};
        `CFA_OFF_RDATA: rmux = {24'h00_0000, resp[rd_idx[5:0]]};
        default: rmux = 32'h0000_0000;
    endcase
end

// ====================================================
// registers, bus slave and command engine
always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
        state <= S_IDLE;
        for (i = 0; i < 64; i = i + 1) begin
            mem[i] <= 8'h00;
            wbuf[i] <= 8'h00;
            resp[i] <= 8'h00;
        end
        cmd <= 32'h0000_0000;
        file_cfg <= `CFA_FILE_RST;
        app_name <= `CFA_APP_RST;
        ptr <= 4'h0;
        app_ind <= 2'b00;
        done <= 1'b0;
        err <= 1'b0;
        resp_len <= 7'h00;
        wr_idx <= 7'h00;
        rd_idx <= 7'h00;
        idx <= 7'h00;
        r_base <= 6'h00;
        r_cnt <= 7'h00;
        r_src <= SRC_MEM;
        r_wr <= 1'b0;
        r_ptr <= 4'h0;
        r_app <= 2'b00;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        BVALID_O <= 1'b0;
        BRESP_O <= `CFA_RESP_OK;
        RVALID_O <= 1'b0;
        RDATA_O <= 32'h0000_0000;
        RRESP_O <= `CFA_RESP_OK;
    end else if (CE_I) begin
        // capture address and data in either order
        if (AWVALID_I && AWREADY_O) begin
            aw_hold <= 1'b1;
            aw_addr <= AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
            w_hold <= 1'b1;
            w_data <= WDATA_I;
            w_strb <= WSTRB_I;
        end
        if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
        end
        if (do_write) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            BVALID_O <= 1'b1;
            BRESP_O <= addr_ok(aw_addr) ? `CFA_RESP_OK : `CFA_RESP_SLVERR;
            // busy engine ignores command and file writes
            if (wr_cmd && state == S_IDLE) begin
                cmd <= merge(cmd, w_data, w_strb);
            end
            if (aw_addr == `CFA_OFF_FILE && state == S_IDLE) begin
                file_cfg <= merge(file_cfg, w_data, w_strb);
                ptr <= 4'h0; // new file, pointer unset
            end
            if (aw_addr == `CFA_OFF_APP) begin
                app_name <= merge(app_name, w_data, w_strb);
            end
            if (aw_addr == `CFA_OFF_WDATA && state == S_IDLE &&
                w_strb[0] && wr_idx != 7'h40) begin
                wbuf[wr_idx[5:0]] <= w_data[7:0];
                wr_idx <= wr_idx + 7'h01;
            end
        end
        // read channel, data port advances on each read until its index reaches 64
        if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
        end
        if (do_read) begin
            RVALID_O <= 1'b1;
            RDATA_O <= rmux;
            RRESP_O <= addr_ok(ARADDR_I) ? `CFA_RESP_OK :
                `CFA_RESP_SLVERR;
            if (ARADDR_I == `CFA_OFF_RDATA && rd_idx != 7'h40) begin
                rd_idx <= rd_idx + 7'h01;
            end
        end
        // command state machine
        case (state)
            S_IDLE: begin
                if (start) begin
                    state <= S_DEC;
                    done <= 1'b0;
                    err <= 1'b0;
                    rd_idx <= 7'h00;
                end
            end
            S_DEC: begin
                if (d_err) begin
                    // nothing stored, pointer kept
                    state <= S_IDLE;
                    err <= 1'b1;
                    done <= 1'b1;
                    resp_len <= 7'h00;
                    wr_idx <= 7'h00;
                end else begin
                    state <= S_RUN;
                    idx <= 7'h00;
                    r_base <= d_off[5:0];
                    r_cnt <= d_cnt[6:0];
                    r_src <= d_src;
                    r_wr <= d_wr;
                    r_ptr <= d_ptr;
                    r_app <= d_app;
                end
            end
            S_RUN: begin
                if (idx == r_cnt) begin
                    state <= S_IDLE;
                    done <= 1'b1;
                    ptr <= r_ptr;
                    app_ind <= r_app;
                    resp_len <= r_wr ? 7'h00 : r_cnt;
                    wr_idx <= 7'h00;
                end else begin
                    if (r_wr) begin
                        mem[r_base + idx[5:0]] <= wbuf[idx[5:0]];
                    end else begin
                        resp[idx[5:0]] <= sbyte;
                    end
                    idx <= idx + 7'h01;
                end
            end
            default: state <= S_IDLE;
        endcase
    end
end

endmodule // cfa_card_file_access

// ---- rtl/cfa_defines.vh ----
// Notes on behaviour
// - status p1: 00 no indication, 01 app initialised, 02 app terminating
// - status p2: 00 select response, 01 app name, 0c nothing, else reserved
// - status expected length may be empty, zero, or a maximum byte count
// - binary and record reads only when the file read condition holds
// - binary update only when update condition holds; overwrites bytes at offset
// - p1 b8 clear: offset is p1 b7..b1 high, p2 low
// - p1 b8 set, b7 b6 clear: p1 b5..b1 short id, p2 offset
// - binary read returns exactly the requested length; no command data
// - binary update decodes like read, length from command field, no response
// - failed record read leaves the record pointer unchanged
// - current mode returns the pointed record, pointer untouched
// - absolute mode returns record number p1, pointer untouched
// - next mode increments first; unset pointer reads and points at first
// - next on linear file at last record: pointer kept, no data
// - next on cyclic file at last record wraps to first and reads it
// - previous decrements first; unset pointer reads and points at last
// - previous on linear file at first record: pointer kept, no data
// - previous on cyclic file at first record wraps to last and reads it
// - record p2 b8..b4: zero current file, else short id 1 to 30
// - record p2 b3..b1: 010 next, 011 previous, 100 absolute or current
// - without explicit short id, short id is low five file id bits
`ifndef CFA_DEFINES_VH
`define CFA_DEFINES_VH
// ====================================================
// register offsets
`define CFA_OFF_CMD 8'h00
`define CFA_OFF_STAT 8'h04
`define CFA_OFF_FILE 8'h08
`define CFA_OFF_APP 8'h0C
`define CFA_OFF_WDATA 8'h10
`define CFA_OFF_RDATA 8'h14
// ====================================================
// reset values
`define CFA_FILE_RST 32'h0000_0000
`define CFA_APP_RST 32'h0000_0000
// ====================================================
// command opcodes
`define CFA_OP_STATUS 2'h0
`define CFA_OP_RD_BIN 2'h1
`define CFA_OP_UP_BIN 2'h2
`define CFA_OP_RD_REC 2'h3
// ====================================================
// file types
`define CFA_FT_TRANSP 2'h0
`define CFA_FT_LINEAR 2'h1
`define CFA_FT_CYCLIC 2'h2
// ====================================================
// status command codings
`define CFA_P1_NONE 8'h00
`define CFA_P1_INIT 8'h01
`define CFA_P1_TERM 8'h02
`define CFA_P2_SELECT 8'h00
`define CFA_P2_NAME 8'h01
`define CFA_P2_NODATA 8'h0C
// ====================================================
// record modes and limits
`define CFA_RM_NEXT 3'h2
`define CFA_RM_PREV 3'h3
`define CFA_RM_ABS 3'h4
`define CFA_SFI_RFU 5'h1F
`define CFA_MEM_BYTES 16'h0040
`define CFA_REC_LEN 9'h008
`define CFA_MAX_REC 4'h8
`define CFA_BIN_LE0 9'h100
`define CFA_SEL_LEN 9'h003
`define CFA_NAME_LEN 9'h004
// ====================================================
// axi responses
`define CFA_RESP_OK 2'h0
`define CFA_RESP_SLVERR 2'h2
`endif

// ---- verification/cfa_axi_monitor.sv ----
`timescale 1ns/1ns
// ==========
// register port checker
module cfa_axi_monitor (
    // clock, enable and reset
    input wire REF_CLK_I,
    input wire RESET_N_I,
    input wire CE_I,
    // write channels
    input wire AWVALID_I,
    input wire AWREADY_O,
    input wire WVALID_I,
    input wire WREADY_O,
    input wire BVALID_O,
    input wire BREADY_I,
    input wire [1:0] BRESP_O,
    // read channels
    input wire ARVALID_I,
    input wire ARREADY_O,
    input wire [7:0] ARADDR_I,
    input wire RVALID_O,
    input wire RREADY_I,
    input wire [31:0] RDATA_O,
    input wire [1:0] RRESP_O
);
    reg [7:0] rd_addr;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // address of the read under way
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I)
            rd_addr <= 8'h00;
        else if (ARVALID_I && ARREADY_O)
            rd_addr <= ARADDR_I;
    end
    // handshake, answer timing and answer content
    a_bresp_holds: assert property (BVALID_O && !BREADY_I
        |=> BVALID_O && $stable(BRESP_O)) else $error("write answer lost");
    a_rresp_holds: assert property (RVALID_O && !RREADY_I
        |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
        else $error("read answer lost");
    a_write_blocked: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write taken while answering");
    a_read_blocked: assert property (RVALID_O |-> !ARREADY_O)
        else $error("read taken while answering");
    a_enable_freeze: assert property (!CE_I
        |-> !AWREADY_O && !WREADY_O && !ARREADY_O) else $error("ready frozen");
    a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
        else $error("read answer late");
    a_write_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I
        && WREADY_O |-> ##2 BVALID_O) else $error("write answer late");
    a_unmapped_read: assert property (ARVALID_I && ARREADY_O
        && ARADDR_I > 8'h14 |=> RRESP_O == 2'h2 && RDATA_O == 32'h0000_0000)
        else $error("unmapped read answered");
    a_error_empty: assert property (RVALID_O && rd_addr == 8'h04
        && RDATA_O[2] |-> RDATA_O[14:8] == 7'h00) else $error("error with data");
endmodule // cfa_axi_monitor
bind cfa_card_file_access cfa_axi_monitor mon (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .ARADDR_I(ARADDR_I), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O));

// ---- verification/cfa_terminal.sv ----
`timescale 1ns/1ns
// ==========
// terminal side register master
module cfa_terminal (
    // clock
    input wire clk_i,
    // write channels
    output reg awvalid_o,
    input wire awready_i,
    output reg [7:0] awaddr_o,
    output reg wvalid_o,
    input wire wready_i,
    output reg [31:0] wdata_o,
    output reg [3:0] wstrb_o,
    input wire bvalid_i,
    output reg bready_o,
    input wire [1:0] bresp_i,
    // read channels
    output reg arvalid_o,
    input wire arready_i,
    output reg [7:0] araddr_o,
    input wire rvalid_i,
    output reg rready_o,
    input wire [31:0] rdata_i,
    input wire [1:0] rresp_i
);
    // idle bus at time zero
    initial begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
        {awaddr_o, araddr_o, wdata_o} = 48'h0;
        wstrb_o = 4'hF;
    end
    // one write, payload inverted once taken
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        begin
            @(posedge clk_i);
            {awvalid_o, wvalid_o, bready_o} <= 3'h7;
            awaddr_o <= a;
            wdata_o <= d;
            do begin
                @(posedge clk_i);
                if (awvalid_o && awready_i) begin
                    awvalid_o <= 1'b0;
                    awaddr_o <= ~a;
                end
                if (wvalid_o && wready_i) begin
                    wvalid_o <= 1'b0;
                    wdata_o <= ~d;
                end
            end while (bvalid_i !== 1'b1);
            r = bresp_i;
            bready_o <= 1'b0;
        end
    endtask
    // one read
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge clk_i);
            {arvalid_o, rready_o} <= 2'h3;
            araddr_o <= a;
            do begin
                @(posedge clk_i);
                if (arvalid_o && arready_i) begin
                    arvalid_o <= 1'b0;
                    araddr_o <= ~a;
                end
            end while (rvalid_i !== 1'b1);
            d = rdata_i;
            r = rresp_i;
            rready_o <= 1'b0;
        end
    endtask
endmodule // cfa_terminal

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`include "cfa_defines.vh"
// ==========
// command bench
module tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg ce = 1'b1;
    wire awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
    wire [7:0] awa, ara;
    wire [31:0] wd, rdat;
    wire [3:0] ws;
    wire [1:0] bresp, rresp;
    integer miscompares = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer j;
    reg [31:0] d, st;
    reg [1:0] r;
    always #50 clk = ~clk;
    // cycle ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end
    cfa_card_file_access uut (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .CE_I(ce), .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
        .WVALID_I(wv), .WREADY_O(wrdy), .WDATA_I(wd), .WSTRB_I(ws),
        .BVALID_O(bv), .BREADY_I(br), .BRESP_O(bresp), .ARVALID_I(arv),
        .ARREADY_O(arr), .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rr),
        .RDATA_O(rdat), .RRESP_O(rresp));
    cfa_terminal term (.clk_i(clk), .awvalid_o(awv), .awready_i(awr),
        .awaddr_o(awa), .wvalid_o(wv), .wready_i(wrdy), .wdata_o(wd),
        .wstrb_o(ws), .bvalid_i(bv), .bready_o(br), .bresp_i(bresp),
        .arvalid_o(arv), .arready_i(arr), .araddr_o(ara), .rvalid_i(rv),
        .rready_o(rr), .rdata_i(rdat), .rresp_i(rresp));
    // compare and count
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] exp, input [1:0] er);
        begin
            term.rd(a, d, r);
            check(d, exp);
            check({30'h0, r}, {30'h0, er});
        end
    endtask
    task wrchk(input [7:0] a, input [31:0] v);
        begin
            term.wr(a, v, r);
            check({30'h0, r}, {30'h0, 2'h0});
        end
    endtask
    // start a command, poll until done, check outcome
    task cmd(input [31:0] w, input e, input [6:0] n, input [3:0] p);
        begin
            term.wr(`CFA_OFF_CMD, w, r);
            repeat (3) @(posedge clk);
            st = 32'h0000_0000;
            // the done bit ends this wait; only the cycle ceiling bounds it
            while (st[1] !== 1'b1)
                term.rd(`CFA_OFF_STAT, st, r);
            check(st & 32'h0000_7FF6, {17'h0, n, p, 1'b0, e, 1'b1, 1'b0});
        end
    endtask
    // drain response bytes, first byte highest in exp
    task rbytes(input [31:0] exp, input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                term.rd(`CFA_OFF_RDATA, d, r);
                check({24'h0, d[7:0]}, {24'h0, exp[31 - 8 * k -: 8]});
            end
        end
    endtask
    task conclude;
        begin
            $display("compared %0d mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`CFA_OFF_STAT, 32'h0000_0000, 2'h0);
        rdchk(`CFA_OFF_FILE, `CFA_FILE_RST, 2'h0);
        rdchk(`CFA_OFF_APP, `CFA_APP_RST, 2'h0);
        rdchk(8'h18, 32'h0000_0000, 2'h2);
        term.wr(8'h18, 32'h0000_0001, r);
        check({30'h0, r}, {30'h0, 2'h2});
        // enable low drops every ready
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        check({29'h0, awr, wrdy, arr}, 32'h0000_0000);
        ce <= 1'b1;
        $display("test reset done");
        wrchk(`CFA_OFF_FILE, 32'h1234_000C);
        wrchk(`CFA_OFF_WDATA, 32'h0000_00A5);
        wrchk(`CFA_OFF_WDATA, 32'h0000_005A);
        cmd(32'h0210_0002, 1'b0, 7'h00, 4'h0);
        cmd(32'h0210_0001, 1'b0, 7'h02, 4'h0);
        rbytes(32'hA55A_0000, 2);
        cmd(32'h0111_9401, 1'b0, 7'h01, 4'h0);
        rbytes(32'h5A00_0000, 1);
        cmd(32'h0110_0101, 1'b1, 7'h00, 4'h0);
        cmd(32'h0110_D401, 1'b1, 7'h00, 4'h0);
        wrchk(`CFA_OFF_FILE, 32'h1234_0008);
        cmd(32'h0210_0001, 1'b1, 7'h00, 4'h0);
        wrchk(`CFA_OFF_FILE, 32'h1234_0004);
        wrchk(`CFA_OFF_WDATA, 32'h0000_00FF);
        cmd(32'h0110_0002, 1'b1, 7'h00, 4'h0);
        wrchk(`CFA_OFF_FILE, 32'h1234_000C);
        cmd(32'h0110_0001, 1'b0, 7'h01, 4'h0);
        rbytes(32'hA500_0000, 1);
        $display("test binary done");
        wrchk(`CFA_OFF_FILE, 32'h0001_0035);
        cmd(32'h0804_0003, 1'b1, 7'h00, 4'h0);
        for (j = 1; j < 4; j = j + 1)
            cmd(32'h0802_0003, 1'b0, 7'h08, j[3:0]);
        cmd(32'h0802_0003, 1'b1, 7'h00, 4'h3);
        cmd(32'h0803_0003, 1'b0, 7'h08, 4'h2);
        cmd(32'h0804_0103, 1'b0, 7'h08, 4'h2);
        cmd(32'h0804_0003, 1'b0, 7'h08, 4'h2);
        cmd(32'h080A_0003, 1'b0, 7'h08, 4'h3);
        cmd(32'h08FA_0003, 1'b1, 7'h00, 4'h3);
        cmd(32'h0805_0003, 1'b1, 7'h00, 4'h3);
        wrchk(`CFA_OFF_FILE, 32'h0001_0035);
        for (j = 3; j > 0; j = j - 1)
            cmd(32'h0803_0003, 1'b0, 7'h08, j[3:0]);
        cmd(32'h0803_0003, 1'b1, 7'h00, 4'h1);
        wrchk(`CFA_OFF_FILE, 32'h0001_0031);
        cmd(32'h0802_0003, 1'b1, 7'h00, 4'h0);
        wrchk(`CFA_OFF_FILE, 32'h0001_0036);
        cmd(32'h0802_0003, 1'b0, 7'h08, 4'h1);
        cmd(32'h0803_0003, 1'b0, 7'h08, 4'h3);
        cmd(32'h0802_0003, 1'b0, 7'h08, 4'h1);
        $display("test record done");
        wrchk(`CFA_OFF_APP, 32'h4142_4344);
        cmd(32'h0000_0104, 1'b0, 7'h03, 4'h1);
        check({30'h0, st[17:16]}, {30'h0, 2'h1});
        rbytes(32'h0001_0100, 3);
        cmd(32'h000C_0200, 1'b0, 7'h00, 4'h1);
        check({30'h0, st[17:16]}, {30'h0, 2'h2});
        cmd(32'h0001_0000, 1'b0, 7'h04, 4'h1);
        rbytes(32'h4142_4344, 4);
        cmd(32'h0200_0000, 1'b0, 7'h02, 4'h1);
        cmd(32'h0005_0100, 1'b1, 7'h00, 4'h1);
        check({30'h0, st[17:16]}, {30'h0, 2'h0});
        $display("test status done");
        conclude;
    end
endmodule // tb_top
